// *** verilog/spio_pkg.sv ***
// Package of register offsets, reset values and sizes for the shared pin port.
`default_nettype none
package spio_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFS_DIR    = 6'h00;
  localparam logic [5:0] OFS_LAT    = 6'h04;
  localparam logic [5:0] OFS_PIN    = 6'h08;
  localparam logic [5:0] OFS_ODC    = 6'h0C;
  localparam logic [5:0] OFS_ANA    = 6'h10;
  localparam logic [5:0] OFS_CNEN_A = 6'h14;
  localparam logic [5:0] OFS_CNEN_B = 6'h18;
  localparam logic [5:0] OFS_CNPU_A = 6'h1C;
  localparam logic [5:0] OFS_CNPU_B = 6'h20;
  localparam logic [5:0] OFS_CNSTAT = 6'h24;
  ////////////////////////////////////////////////////////////////////////////
  // Sizes and reset values.
  localparam int          PORT_W     = 16;
  localparam int          CN_MAX     = 31;
  localparam int          CN_HALF    = 16;
  localparam int          RP_MAX     = 26;
  localparam logic [15:0] DIR_RST    = 16'hFFFF;
  localparam logic [15:0] LAT_RST    = 16'h0000;
  localparam logic [15:0] ODC_RST    = 16'h0000;
  localparam logic [15:0] ANA_RST    = 16'h0000;
  localparam logic [30:0] CN_RST     = 31'h00000000;
endpackage
`default_nettype wire

// *** verilog/spio_port.sv ***
// Shared pin parallel port with change notification behind an Avalon-MM slave.
`default_nettype none
// What this block does
// - Active peripheral owns pin, port driver off
// - Idle enabled peripheral lets port drive pin
// - Peripheral input never sees port latch
// - Direction bit one is input, zero output
// - Every reset makes all pins inputs
// - Latch register reads and writes the latch
// - Pin register reads pins, writes latch
// - Unimplemented bits read zero everywhere
// - Open-drain bit makes driver open-drain
// - Analog config resets to zero, analog mode
// - Analog pins read zero in pin register
// - Change on selected pin raises interrupt
// - Up to 31 change watch pins
// - Per-pin change enables in two registers
// - Per-pin pull-ups in two registers
// - Remappable pins are fixed subset up to 26
// - Remapped input and output are independent
// - Input-only shared pin acts as dedicated
module spio_port
  import spio_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter logic [15:0] ANA_MASK  = 16'h000F,
  parameter logic [15:0] RP_MASK   = 16'hFFFF,
  parameter int          CN_PINS   = 31
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              nrst,
  // Avalon-MM slave.
  input  wire logic [5:0]        avAddress,
  input  wire logic              avRead,
  input  wire logic              avWrite,
  input  wire logic [31:0]       avWritedata,
  output var  logic [31:0]       avReaddata,
  output var  logic              avWaitrequest,
  // Pads.
  input  wire logic [15:0]       padIn,
  output var  logic [15:0]       padOut,
  output var  logic [15:0]       padOe,
  // Peripheral side of the shared pins.
  input  wire logic [15:0]       periphEn,
  input  wire logic [15:0]       periphDrive,
  input  wire logic [15:0]       periphOut,
  output var  logic [15:0]       periphIn,
  // Change watch pins and their pull-ups.
  input  wire logic [CN_PINS-1:0] changeWatchPin,
  output var  logic [CN_PINS-1:0] pullupEn,
  output var  logic              changeIrq
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers and internal signals.
  logic [15:0]  dir_q;
  logic [15:0]  lat_q;
  logic [15:0]  odc_q;
  logic [15:0]  ana_q;
  logic [30:0]  cnEn_q;
  logic [30:0]  cnPu_q;
  logic [30:0]  cnStat_q;
  logic [30:0]  cnStat_d;
  logic [30:0]  cnPrev_q;
  logic [30:0]  cnNow;
  logic [30:0]  cnMask;
  logic         wait_q;
  logic [31:0]  rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. A request is answered on the second cycle it is held.
  wire          req     = avRead | avWrite;
  wire          accept  = req & ~wait_q;
  wire          wrEn    = avWrite & accept;
  wire          hitDir  = (avAddress == OFS_DIR);
  wire          hitLat  = (avAddress == OFS_LAT);
  wire          hitPin  = (avAddress == OFS_PIN);
  wire          hitOdc  = (avAddress == OFS_ODC);
  wire          hitAna  = (avAddress == OFS_ANA);
  wire          hitEnA  = (avAddress == OFS_CNEN_A);
  wire          hitEnB  = (avAddress == OFS_CNEN_B);
  wire          hitPuA  = (avAddress == OFS_CNPU_A);
  wire          hitPuB  = (avAddress == OFS_CNPU_B);
  wire          hitStat = (avAddress == OFS_CNSTAT);
  wire [15:0]   wd      = avWritedata[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership and drivers.
  // A peripheral that is enabled and driving takes the pin.
  wire [15:0]   periphOwns = periphEn & periphDrive & RP_MASK;
  // Otherwise the port drives when its direction bit is zero.
  wire [15:0]   portDrives = ~periphOwns & ~dir_q;
  wire [15:0]   drvVal     = (periphOwns & periphOut) | (~periphOwns & lat_q);
  wire [15:0]   drvEn      = (periphOwns | portDrives) & IMPL_MASK;
  // Open-drain pins only ever pull low.
  wire [15:0]   oeNext     = drvEn & (~odc_q | ~drvVal);
  wire [15:0]   outNext    = drvVal & ~odc_q & IMPL_MASK;
  // Analog pins (config bit zero) read as low.
  wire [15:0]   isAnalog   = ANA_MASK & ~ana_q;
  wire [15:0]   pinRead    = padIn & ~isAnalog & IMPL_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Change notification.
  // Event on any enabled pin whose level differs from the last sample.
  assign cnMask = (31'(1) << CN_PINS) - 31'(1);
  assign cnNow  = 31'(changeWatchPin) & cnMask;
  wire [30:0]   cnEvent  = (cnNow ^ cnPrev_q) & cnEn_q;
  wire [30:0]   cnClrA   = {15'h0000, wd} & {31{wrEn & hitStat}};
  wire [30:0]   cnClrB   = {avWritedata[30:16], 16'h0000} & {31{wrEn & hitStat}};

  // Set wins over a write-one-to-clear in the same cycle.
  always_comb begin
    cnStat_d = ((cnStat_q & ~(cnClrA | cnClrB)) | cnEvent) & cnMask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.
  wire [31:0]   rdMux =
      hitDir  ? {16'h0000, dir_q & IMPL_MASK} :
      hitLat  ? {16'h0000, lat_q & IMPL_MASK} :
      hitPin  ? {16'h0000, pinRead} :
      hitOdc  ? {16'h0000, odc_q & IMPL_MASK} :
      hitAna  ? {16'h0000, ana_q & ANA_MASK} :
      hitEnA  ? {16'h0000, cnEn_q[15:0]} :
      hitEnB  ? {17'h00000, cnEn_q[30:16]} :
      hitPuA  ? {16'h0000, cnPu_q[15:0]} :
      hitPuB  ? {17'h00000, cnPu_q[30:16]} :
      hitStat ? {1'b0, cnStat_q} :
      32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (avRead & wait_q) ? rdMux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= DIR_RST;
      lat_q <= LAT_RST;
      odc_q <= ODC_RST;
      ana_q <= ANA_RST;
    end else begin
      if (wrEn && hitDir) begin
        dir_q <= wd;
      end
      if (wrEn && (hitLat || hitPin)) begin
        lat_q <= wd;
      end
      if (wrEn && hitOdc) begin
        odc_q <= wd;
      end
      if (wrEn && hitAna) begin
        ana_q <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change notification registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnEn_q   <= CN_RST;
      cnPu_q   <= CN_RST;
      cnStat_q <= CN_RST;
      cnPrev_q <= CN_RST;
    end else begin
      if (wrEn && hitEnA) begin
        cnEn_q[15:0] <= wd & cnMask[15:0];
      end
      if (wrEn && hitEnB) begin
        cnEn_q[30:16] <= avWritedata[30:16] & cnMask[30:16];
      end
      if (wrEn && hitPuA) begin
        cnPu_q[15:0] <= wd & cnMask[15:0];
      end
      if (wrEn && hitPuB) begin
        cnPu_q[30:16] <= avWritedata[30:16] & cnMask[30:16];
      end
      cnStat_q <= cnStat_d;
      cnPrev_q <= cnNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      padOut    <= 16'h0000;
      padOe     <= 16'h0000;
      periphIn  <= 16'h0000;
      pullupEn  <= '0;
      changeIrq <= 1'b0;
    end else begin
      padOut    <= outNext;
      padOe     <= oeNext;
      // Peripherals see only the pad, never the port latch.
      periphIn  <= padIn & IMPL_MASK;
      pullupEn  <= cnPu_q[CN_PINS-1:0];
      changeIrq <= |cnStat_d;
    end
  end

  assign avReaddata    = rdata_q;
  assign avWaitrequest = wait_q;

endmodule
`default_nettype wire

// *** verif/spio_port_props.sv ***
// Concurrent checks of the shared pin port at its ports.
`default_nettype none
module spio_port_props
  import spio_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter int          CN_PINS   = 31
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic [5:0]         avAddress,
  input wire logic               avRead,
  input wire logic               avWrite,
  input wire logic [31:0]        avReaddata,
  input wire logic               avWaitrequest,
  input wire logic [15:0]        padIn,
  input wire logic [15:0]        padOut,
  input wire logic [15:0]        padOe,
  input wire logic [15:0]        periphIn,
  input wire logic [CN_PINS-1:0] pullupEn,
  input wire logic               changeIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic wrDone = avWrite && !avWaitrequest;
  wire logic clrHit = wrDone && avAddress == OFS_CNSTAT;
  AST_RST_INPUTS: assert property (!$past(nrst) |-> padOe == 16'h0000)
    else $error("pins driven right after reset");
  AST_IRQ_CLEAR: assert property ($fell(changeIrq) |-> $past(clrHit))
    else $error("change request dropped without a clear");
  AST_WAIT_PULSE: assert property (!avWaitrequest |=> avWaitrequest)
    else $error("wait request low for more than one cycle");
  AST_ANSWER: assert property ((avRead || avWrite) && avWaitrequest |=> !avWaitrequest)
    else $error("request not answered in one cycle");
  AST_RDATA_IDLE: assert property (avWaitrequest |-> avReaddata == 32'h00000000)
    else $error("read data outside the answer cycle");
  AST_UNIMPL: assert property (((padOe | padOut | periphIn) & ~IMPL_MASK) == 16'h0000)
    else $error("unimplemented pin active");
  AST_NO_LOOP: assert property ($past(nrst) |-> periphIn == ($past(padIn) & IMPL_MASK))
    else $error("peripheral input is not the pad level");
  AST_PULLUP: assert property (!$stable(pullupEn) |-> $past(wrDone) || $past(wrDone, 2))
    else $error("pull-ups changed without a write");
endmodule
bind spio_port spio_port_props #(.IMPL_MASK(IMPL_MASK), .CN_PINS(CN_PINS)) i_spio_port_props (
  .clk, .nrst, .avAddress, .avRead, .avWrite, .avReaddata, .avWaitrequest,
  .padIn, .padOut, .padOe, .periphIn, .pullupEn, .changeIrq);
`default_nettype wire

// *** verif/spio_pads.sv ***
// Model of the board circuitry that sits on the port pads.
`default_nettype none
module spio_pads (
  input  wire logic        clk,
  input  wire logic [15:0] padOut,
  input  wire logic [15:0] padOe,
  input  wire logic [15:0] pullUp,
  input  wire logic [15:0] extVal,
  input  wire logic [15:0] extOe,
  output var  logic [15:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lastQ = 16'h0000;
  // An undriven pad without pull-up shows a value that keeps changing.
  assign padIn = (padOe & padOut) | (~padOe & extOe & extVal)
               | (~padOe & ~extOe & (pullUp | ~lastQ));
  always @(posedge clk) begin
    lastQ <= padIn;
  end
endmodule
`default_nettype wire

// *** verif/test_spio_port.sv ***
// Self-checking bench of the shared pin port.
`default_nettype none
module test_spio_port
  import spio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] M = 16'h7FFF;
  logic clk = 0, nrst = 0, avRead = 0, avWrite = 0, changeIrq, avWaitrequest;
  logic [5:0]  avAddress = 0;
  logic [31:0] avWritedata = 0, avReaddata, v, q;
  logic [15:0] padIn, padOut, padOe, periphIn, extVal = 0, extOe = 16'hFFFF;
  logic [15:0] periphEn = 0, periphDrive = 0, periphOut = 0;
  logic [30:0] cw = 0, pullupEn;
  int seed = 3017, badCount = 0, totalChecks = 0, cyc = 0, k;
  spio_port #(.IMPL_MASK(M)) i_spio_port (.clk, .nrst, .avAddress, .avRead, .avWrite,
    .avWritedata, .avReaddata, .avWaitrequest, .padIn, .padOut, .padOe, .periphEn,
    .periphDrive, .periphOut, .periphIn, .changeWatchPin(cw), .pullupEn, .changeIrq);
  spio_pads i_spio_pads (.clk, .padOut, .padOe, .pullUp(pullupEn[15:0]), .extVal, .extOe,
    .padIn);
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      badCount++;
      reportAndStop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      badCount++;
      $display("BAD t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avAddress <= a;
    avWrite <= w;
    avRead <= !w;
    avWritedata <= d;
    @(posedge clk);
    while (avWaitrequest !== 1'b0) @(posedge clk);
    q = avReaddata;
    avRead <= 1'b0;
    avWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(q, e);
  endtask
  function automatic logic [31:0] pinExp(input logic [15:0] ext, input logic [15:0] ana);
    return {16'h0000, ext & M & (ana | ~16'h000F)};
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(OFS_DIR, {16'h0000, DIR_RST & M});
    rd(OFS_ANA, {16'h0000, ANA_RST});
    rd(6'h3C, 32'h00000000);
    for (k = 0; k < 8; k++) begin
      v = $random(seed);
      bus(1'b1, OFS_LAT, v);
      rd(OFS_LAT, v & M);
      bus(1'b1, OFS_PIN, ~v);
      rd(OFS_LAT, ~v & M);
      extVal <= v[31:16];
      bus(1'b1, OFS_ANA, v);
      rd(OFS_PIN, pinExp(v[31:16], v[15:0]));
    end
    $display("test registers done");
    bus(1'b1, OFS_LAT, v);
    bus(1'b1, OFS_DIR, 32'h00000000);
    periphEn <= 16'hFFFF;
    periphOut <= ~v[15:0];
    repeat (2) @(posedge clk);
    chk(padOe, M);
    chk(padOut, v & M);
    periphDrive <= 16'hFFFF;
    repeat (2) @(posedge clk);
    chk(padOut, ~v & M);
    periphEn <= 16'h0000;
    bus(1'b1, OFS_ODC, 32'h0000FFFF);
    @(posedge clk);
    chk(padOut, 32'h00000000);
    chk(padOe, ~v & M);
    $display("test drivers done");
    bus(1'b1, OFS_CNEN_A, 32'h0000FFFF);
    bus(1'b1, OFS_CNEN_B, 32'h7FFF0000);
    rd(OFS_CNEN_B, 32'h00007FFF);
    for (k = 0; k < 4; k++) begin
      v = (k == 0) ? 0 : (k == 1) ? 30 : $unsigned($random(seed)) % 31;
      cw[v] <= ~cw[v];
      repeat (3) @(posedge clk);
      chk(changeIrq, 1'b1);
      rd(OFS_CNSTAT, 32'h1 << v);
      bus(1'b1, OFS_CNSTAT, 32'h1 << v);
      @(posedge clk);
      chk(changeIrq, 1'b0);
    end
    bus(1'b1, OFS_CNEN_A, 32'h00000000);
    bus(1'b1, OFS_CNEN_B, 32'h00000000);
    cw <= ~cw;
    repeat (3) @(posedge clk);
    chk(changeIrq, 1'b0);
    bus(1'b1, OFS_DIR, 32'h0000FFFF);
    v = $random(seed);
    bus(1'b1, OFS_CNPU_A, v);
    bus(1'b1, OFS_CNPU_B, v);
    @(posedge clk);
    chk(pullupEn, v[30:0]);
    $display("test change watch done");
    reportAndStop();
  end
endmodule
`default_nettype wire
